// >>> hdl/qll_pkg.sv
package qll_pkg;
	// ----------------------------------------
	// Register map: indices, byte address = 4 * index
	// ----------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] IDX_TIMERS = 12'h02c;
	localparam logic [ADDR_W-1:0] IDX_CTRL = 12'h02d;
	localparam logic [ADDR_W-1:0] IDX_THRESH = 12'h02e;
	localparam logic [ADDR_W-1:0] IDX_CFG3 = 12'h031;
	localparam logic [ADDR_W-1:0] IDX_IRQ_STAT = 12'h040;
	localparam logic [ADDR_W-1:0] IDX_IRQ_MASK = 12'h041;
	localparam logic [ADDR_W-1:0] IDX_XOVER = 12'h042;

	localparam logic [15:0] RST_TIMERS = 16'h141f;
	localparam logic [15:0] RST_CTRL = 16'h0000;
	localparam logic [15:0] RST_THRESH = 16'h0221;
	localparam logic [15:0] RST_CFG3 = 16'h10b0;
	localparam logic [15:0] WMASK_TIMERS = 16'h3fff;
	localparam logic [15:0] WMASK_CTRL = 16'hc01f;
	localparam logic [15:0] WMASK_THRESH = 16'h0777;
	localparam logic [15:0] WMASK_CFG3 = 16'h71fd;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int LWIN_LSB = 9;
	localparam int FAST_LSB = 4;
	localparam int SLOW_LSB = 0;
	localparam int FORCE_BIT = 15;
	localparam int SKIP_BIT = 14;
	localparam int STUCK_BIT = 13;
	localparam int LATCH_LSB = 8;
	localparam int MODES_LSB = 0;
	localparam int EWIN_LSB = 8;
	localparam int EON_LSB = 4;
	localparam int ELOST_LSB = 0;
	localparam int AN_LSB = 5;
	localparam int NCRIT = 5;
	localparam int IRQ_W = 7;
	localparam int IRQ_DROP = 5;
	localparam int IRQ_AN = 6;
	localparam int XO_EN_BIT = 0;
	localparam int XO_ROBUST_BIT = 1;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int OBS_STEP_NS = 1000;
	localparam int OBS_STEP_CYC = OBS_STEP_NS / CLK_PERIOD_NS;
	localparam int MAX_WAIT_NS = 10000;
	localparam int MAX_WAIT_CYC = MAX_WAIT_NS / CLK_PERIOD_NS;
	localparam int ENERGY_STEP_CYC = 8;
	localparam int FAST_STEP_NS = 4000000;
	localparam int FAST_STEP_CYC = FAST_STEP_NS / CLK_PERIOD_NS;
	localparam int ROBUST_TOTAL_NS = 500000000;
	localparam int ROBUST_DEFAULT_VAL = 15;
	localparam int ROBUST_STEP_CYC = ROBUST_TOTAL_NS / ROBUST_DEFAULT_VAL / CLK_PERIOD_NS;
	localparam int AN_T0_NS = 1600000;
	localparam int AN_T1_NS = 2000;
	localparam int AN_T2_NS = 800000;
	localparam int AN_T3_NS = 11000000;
	localparam int AN_T0_CYC = AN_T0_NS / CLK_PERIOD_NS;
	localparam int AN_T1_CYC = AN_T1_NS / CLK_PERIOD_NS;
	localparam int AN_T2_CYC = AN_T2_NS / CLK_PERIOD_NS;
	localparam int AN_T3_CYC = AN_T3_NS / CLK_PERIOD_NS;

	// Receive-path indications, same bit order as the criterion enables
	typedef struct packed {
		logic descr_loss;
		logic rx_err;
		logic mlt3_err;
		logic mse_bad;
		logic energy_lost;
	} qll_crit_t;

	typedef enum logic [1:0] {LINK_OK, WAIT_MAX, LINK_DOWN} qll_link_t;
endpackage : qll_pkg

// >>> hdl/qll_energy_acc.sv
`timescale 1ns/1ps
module qll_energy_acc (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic energy_det_in,
	input wire logic [2:0] window_in,
	input wire logic [2:0] on_thr_in,
	input wire logic [2:0] lost_thr_in,
	output logic present_out,
	output logic lost_out
);
	logic [2:0] step_cnt_reg;
	logic [2:0] win_cnt_reg;
	logic [6:0] acc_reg;
	logic [6:0] acc_next;
	wire step_end = step_cnt_reg == 3'(qll_pkg::ENERGY_STEP_CYC - 1);
	wire win_end = step_end && (win_cnt_reg == window_in);

	assign acc_next = acc_reg + {6'h00, energy_det_in};

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			step_cnt_reg <= 3'h0;
			win_cnt_reg <= 3'h0;
			acc_reg <= 7'h00;
			present_out <= 1'b0;
			lost_out <= 1'b0;
		end else begin
			step_cnt_reg <= step_cnt_reg + 3'h1;
			if (step_end) begin
				win_cnt_reg <= win_end ? 3'h0 : win_cnt_reg + 3'h1;
			end
			acc_reg <= win_end ? 7'h00 : acc_next;
			if (win_end) begin
				present_out <= acc_next > {4'h0, on_thr_in};
				lost_out <= acc_next < {4'h0, lost_thr_in};
			end
		end
	end

	chk_present_thr: assert property (@(posedge clk_in) disable iff (rst_in)
		win_end |=> present_out == ($past(acc_next) > {4'h0, $past(on_thr_in)}))
		else $error("energy present not tied to threshold");
	chk_lost_thr: assert property (@(posedge clk_in) disable iff (rst_in)
		win_end |=> lost_out == ($past(acc_next) < {4'h0, $past(lost_thr_in)}))
		else $error("energy lost not tied to threshold");
	chk_flags_hold: assert property (@(posedge clk_in) disable iff (rst_in)
		!win_end |=> $stable(present_out) && $stable(lost_out))
		else $error("energy flags moved inside a window");
endmodule : qll_energy_acc

// >>> hdl/qll_top.sv
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Loss criteria are judged over an observation window set by a five-bit count, default near ten microseconds.
// - In forced-100M fast crossover mode the pair mapping flips after a short five-bit interval, default near 4 ms.
// - In robust crossover mode the pair mapping flips after a four-bit interval, default near half a second.
// - With forced drop enabled, the link drops and transmit stops whenever no signal is received.
// - With the skip bit set, the maximum-wait stage is bypassed and the link drops at once.
// - Five read-only event bits latch high on their event and clear when software reads that register.
// - Five independent enables select energy loss, MSE, MLT-3 errors, receive error and descrambler sync loss.
// - Energy-detector output is accumulated over a window set by a three-bit field, default 2.
// - Energy present is flagged when the accumulator exceeds a three-bit threshold, default 2.
// - Energy lost is flagged when the accumulator falls below a separate three-bit threshold, default 1.
// - The SGMII negotiation timer lasts 1.6 ms, 2 us, 800 us or 11 ms by a two-bit code, reset code 01.
module qll_top #(
	parameter int FAST_STEP_CYC = qll_pkg::FAST_STEP_CYC,
	parameter int ROBUST_STEP_CYC = qll_pkg::ROBUST_STEP_CYC,
	parameter int AN_T0_CYC = qll_pkg::AN_T0_CYC,
	parameter int AN_T2_CYC = qll_pkg::AN_T2_CYC,
	parameter int AN_T3_CYC = qll_pkg::AN_T3_CYC
) (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic [11:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [11:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic ENERGY_DET_IN,
	input wire logic MSE_BAD_IN,
	input wire logic MLT3_ERR_IN,
	input wire logic RX_ERR_IN,
	input wire logic DESCR_LOSS_IN,
	input wire logic SIGNAL_DET_IN,
	input wire logic SLICER_STUCK_IN,
	input wire logic AN_START_IN,
	output logic LINK_DOWN_OUT,
	output logic TX_STOP_OUT,
	output logic MDIX_OUT,
	output logic AN_DONE_OUT,
	output logic IRQ_OUT
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	localparam int NSYNC = 8;
	logic [NSYNC-1:0] sync1_reg;
	logic [NSYNC-1:0] sync2_reg;
	wire [NSYNC-1:0] raw_in = {AN_START_IN, SLICER_STUCK_IN, SIGNAL_DET_IN, DESCR_LOSS_IN,
		RX_ERR_IN, MLT3_ERR_IN, MSE_BAD_IN, ENERGY_DET_IN};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
				if (RST_IN) begin
					sync1_reg[gi] <= 1'b0;
					sync2_reg[gi] <= 1'b0;
				end else begin
					sync1_reg[gi] <= raw_in[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate
	wire energy_det = sync2_reg[0];
	wire sig_det = sync2_reg[5];
	wire stuck = sync2_reg[6];
	wire an_start = sync2_reg[7];

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [15:0] timers_reg;
	logic [15:0] ctrl_reg;
	logic [15:0] thresh_reg;
	logic [15:0] cfg3_reg;
	logic [qll_pkg::IRQ_W-1:0] irq_stat_reg;
	logic [qll_pkg::IRQ_W-1:0] irq_mask_reg;
	logic [1:0] xo_ctl_reg;
	logic [qll_pkg::NCRIT-1:0] latch_reg;

	wire [4:0] loss_window_count = timers_reg[qll_pkg::LWIN_LSB +: 5];
	wire [4:0] quick_crossover_interval = timers_reg[qll_pkg::FAST_LSB +: 5];
	wire [3:0] slow_crossover_interval = timers_reg[qll_pkg::SLOW_LSB +: 4];
	wire force_drop = ctrl_reg[qll_pkg::FORCE_BIT];
	wire skip_wait_stage = ctrl_reg[qll_pkg::SKIP_BIT];
	wire [4:0] crit_enable = ctrl_reg[qll_pkg::MODES_LSB +: 5];
	wire [2:0] energy_accum_window = thresh_reg[qll_pkg::EWIN_LSB +: 3];
	wire [2:0] energy_present_threshold = thresh_reg[qll_pkg::EON_LSB +: 3];
	wire [2:0] energy_absent_threshold = thresh_reg[qll_pkg::ELOST_LSB +: 3];
	wire [1:0] serial_negotiation_duration = cfg3_reg[qll_pkg::AN_LSB +: 2];

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	logic aw_have_reg;
	logic w_have_reg;
	logic [11:0] waddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;

	function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] d,
		input logic [3:0] s, input logic [15:0] m);
		logic [15:0] v;
		v = old_v;
		if (s[0]) v[7:0] = d[7:0];
		if (s[1]) v[15:8] = d[15:8];
		return (v & m) | (old_v & ~m);
	endfunction : merge16

	wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
	wire w_take = S_AXI_WVALID && S_AXI_WREADY;
	wire do_write = aw_have_reg && w_have_reg && !S_AXI_BVALID;
	wire [11:0] widx = {2'h0, waddr_reg[11:2]};
	wire wr_timers = do_write && widx == qll_pkg::IDX_TIMERS;
	wire wr_ctrl = do_write && widx == qll_pkg::IDX_CTRL;
	wire wr_thresh = do_write && widx == qll_pkg::IDX_THRESH;
	wire wr_cfg3 = do_write && widx == qll_pkg::IDX_CFG3;
	wire wr_stat = do_write && widx == qll_pkg::IDX_IRQ_STAT;
	wire wr_mask = do_write && widx == qll_pkg::IDX_IRQ_MASK;
	wire wr_xo = do_write && widx == qll_pkg::IDX_XOVER;
	wire wr_hit = wr_timers || wr_ctrl || wr_thresh || wr_cfg3 || wr_stat || wr_mask || wr_xo;
	wire ro_write = do_write && !wr_hit;
	// Next mask value, so the interrupt level never lags a mask write
	wire [qll_pkg::IRQ_W-1:0] irq_mask_next = (wr_mask && wstrb_reg[0]) ? wdata_reg[qll_pkg::IRQ_W-1:0] : irq_mask_reg;

	wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;
	wire [11:0] ridx = {2'h0, S_AXI_ARADDR[11:2]};
	wire rd_ctrl = ar_take && ridx == qll_pkg::IDX_CTRL;
	wire [15:0] ctrl_view = {ctrl_reg[15:14], stuck, latch_reg, 3'h0, ctrl_reg[4:0]};
	logic [15:0] rd_mux;
	logic rd_ok;
	always_comb begin
		rd_ok = 1'b1;
		case (ridx)
			qll_pkg::IDX_TIMERS: rd_mux = timers_reg;
			qll_pkg::IDX_CTRL: rd_mux = ctrl_view;
			qll_pkg::IDX_THRESH: rd_mux = thresh_reg;
			qll_pkg::IDX_CFG3: rd_mux = cfg3_reg;
			qll_pkg::IDX_IRQ_STAT: rd_mux = {9'h000, irq_stat_reg};
			qll_pkg::IDX_IRQ_MASK: rd_mux = {9'h000, irq_mask_reg};
			qll_pkg::IDX_XOVER: rd_mux = {14'h0000, xo_ctl_reg};
			default: begin
				rd_mux = 16'h0000;
				rd_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			waddr_reg <= 12'h000;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= qll_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_have_reg <= 1'b1;
				waddr_reg <= S_AXI_AWADDR;
				S_AXI_AWREADY <= 1'b0;
			end
			if (w_take) begin
				w_have_reg <= 1'b1;
				wdata_reg <= S_AXI_WDATA;
				wstrb_reg <= S_AXI_WSTRB;
				S_AXI_WREADY <= 1'b0;
			end
			if (do_write) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= ro_write ? qll_pkg::RESP_SLVERR : qll_pkg::RESP_OKAY;
			end else if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= qll_pkg::RESP_OKAY;
		end else if (ar_take) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= {16'h0000, rd_mux};
			S_AXI_RRESP <= rd_ok ? qll_pkg::RESP_OKAY : qll_pkg::RESP_SLVERR;
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_ARREADY <= 1'b1;
		end
	end

	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			timers_reg <= qll_pkg::RST_TIMERS;
			ctrl_reg <= qll_pkg::RST_CTRL;
			thresh_reg <= qll_pkg::RST_THRESH;
			cfg3_reg <= qll_pkg::RST_CFG3;
			irq_mask_reg <= '0;
			xo_ctl_reg <= 2'h0;
		end else begin
			if (wr_timers) timers_reg <= merge16(timers_reg, wdata_reg, wstrb_reg, qll_pkg::WMASK_TIMERS);
			if (wr_ctrl) ctrl_reg <= merge16(ctrl_reg, wdata_reg, wstrb_reg, qll_pkg::WMASK_CTRL);
			if (wr_thresh) thresh_reg <= merge16(thresh_reg, wdata_reg, wstrb_reg, qll_pkg::WMASK_THRESH);
			if (wr_cfg3) cfg3_reg <= merge16(cfg3_reg, wdata_reg, wstrb_reg, qll_pkg::WMASK_CFG3);
			irq_mask_reg <= irq_mask_next;
			if (wr_xo && wstrb_reg[0]) xo_ctl_reg <= wdata_reg[1:0];
		end
	end

	// ----------------------------------------
	// Energy accumulator and criteria
	// ----------------------------------------
	logic energy_present;
	logic energy_lost;
	qll_energy_acc u_energy (
		.clk_in(CLOCK_IN),
		.rst_in(RST_IN),
		.energy_det_in(energy_det),
		.window_in(energy_accum_window),
		.on_thr_in(energy_present_threshold),
		.lost_thr_in(energy_absent_threshold),
		.present_out(energy_present),
		.lost_out(energy_lost)
	);
	qll_pkg::qll_crit_t crit_now;
	assign crit_now = '{descr_loss: sync2_reg[4], rx_err: sync2_reg[3], mlt3_err: sync2_reg[2],
		mse_bad: sync2_reg[1], energy_lost: energy_lost};

	// ----------------------------------------
	// Observation window
	// ----------------------------------------
	logic [7:0] obs_step_reg;
	logic [4:0] obs_win_reg;
	logic [qll_pkg::NCRIT-1:0] crit_seen_reg;
	wire obs_step_end = obs_step_reg == 8'(qll_pkg::OBS_STEP_CYC - 1);
	wire obs_end = obs_step_end && (obs_win_reg + 5'h1 >= loss_window_count);
	// Any enabled criterion seen during the window counts as met
	wire [qll_pkg::NCRIT-1:0] crit_hit = (crit_seen_reg | crit_now) & crit_enable;
	wire loss_hit = obs_end && (|crit_hit);
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			obs_step_reg <= 8'h00;
			obs_win_reg <= 5'h00;
			crit_seen_reg <= '0;
		end else begin
			obs_step_reg <= obs_step_end ? 8'h00 : obs_step_reg + 8'h01;
			if (obs_step_end) obs_win_reg <= obs_end ? 5'h00 : obs_win_reg + 5'h01;
			crit_seen_reg <= obs_end ? '0 : crit_seen_reg | crit_now;
			// New count restarts the window, so it never runs past a shortened count
			if (wr_timers) begin
				obs_step_reg <= 8'h00;
				obs_win_reg <= 5'h00;
			end
		end
	end

	// ----------------------------------------
	// Link drop state
	// ----------------------------------------
	qll_pkg::qll_link_t link_reg;
	qll_pkg::qll_link_t link_next;
	logic [11:0] wait_reg;
	wire no_signal_drop = force_drop && !sig_det;
	wire wait_done = wait_reg == 12'(qll_pkg::MAX_WAIT_CYC - 1);
	always_comb begin
		case (link_reg)
			qll_pkg::LINK_OK: begin
				if (no_signal_drop || (loss_hit && skip_wait_stage)) link_next = qll_pkg::LINK_DOWN;
				else if (loss_hit) link_next = qll_pkg::WAIT_MAX;
				else link_next = qll_pkg::LINK_OK;
			end
			qll_pkg::WAIT_MAX: link_next = (wait_done || no_signal_drop) ? qll_pkg::LINK_DOWN : qll_pkg::WAIT_MAX;
			qll_pkg::LINK_DOWN: begin
				// Recovery needs fresh energy and a quiet receive path
				link_next = (energy_present && crit_now == '0 && !no_signal_drop) ? qll_pkg::LINK_OK
					: qll_pkg::LINK_DOWN;
			end
			default: link_next = qll_pkg::LINK_OK;
		endcase
	end
	wire drop_now = link_next == qll_pkg::LINK_DOWN && link_reg != qll_pkg::LINK_DOWN;
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			link_reg <= qll_pkg::LINK_OK;
			wait_reg <= 12'h000;
			LINK_DOWN_OUT <= 1'b0;
			TX_STOP_OUT <= 1'b0;
		end else begin
			link_reg <= link_next;
			wait_reg <= (link_reg == qll_pkg::WAIT_MAX) ? wait_reg + 12'h001 : 12'h000;
			LINK_DOWN_OUT <= link_next == qll_pkg::LINK_DOWN;
			TX_STOP_OUT <= link_next == qll_pkg::LINK_DOWN;
		end
	end

	// ----------------------------------------
	// Event latch, cleared by reading; a new event wins
	// ----------------------------------------
	wire [qll_pkg::NCRIT-1:0] latch_set = loss_hit ? crit_hit : '0;
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) latch_reg <= '0;
		else latch_reg <= (rd_ctrl ? '0 : latch_reg) | latch_set;
	end

	// ----------------------------------------
	// Crossover timer
	// ----------------------------------------
	logic [23:0] xo_cyc_reg;
	logic [4:0] xo_step_reg;
	wire xo_robust = xo_ctl_reg[qll_pkg::XO_ROBUST_BIT];
	wire xo_run = xo_ctl_reg[qll_pkg::XO_EN_BIT] && !sig_det;
	wire [23:0] xo_step_last = xo_robust ? 24'(ROBUST_STEP_CYC - 1) : 24'(FAST_STEP_CYC - 1);
	wire [4:0] xo_steps = xo_robust ? {1'b0, slow_crossover_interval} : quick_crossover_interval;
	wire xo_flip = xo_run && xo_cyc_reg == xo_step_last && xo_step_reg + 5'h1 >= xo_steps;
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			xo_cyc_reg <= 24'h000000;
			xo_step_reg <= 5'h00;
			MDIX_OUT <= 1'b0;
		end else if (!xo_run) begin
			xo_cyc_reg <= 24'h000000;
			xo_step_reg <= 5'h00;
		end else begin
			xo_cyc_reg <= (xo_cyc_reg == xo_step_last) ? 24'h000000 : xo_cyc_reg + 24'h000001;
			if (xo_cyc_reg == xo_step_last) xo_step_reg <= xo_flip ? 5'h00 : xo_step_reg + 5'h01;
			if (xo_flip) MDIX_OUT <= !MDIX_OUT;
		end
	end

	// ----------------------------------------
	// SGMII negotiation timer
	// ----------------------------------------
	logic [21:0] an_cnt_reg;
	logic an_busy_reg;
	logic an_start_d_reg;
	logic [21:0] an_last;
	always_comb begin
		case (serial_negotiation_duration)
			2'h0: an_last = 22'(AN_T0_CYC - 1);
			2'h1: an_last = 22'(qll_pkg::AN_T1_CYC - 1);
			2'h2: an_last = 22'(AN_T2_CYC - 1);
			default: an_last = 22'(AN_T3_CYC - 1);
		endcase
	end
	wire an_fire = an_start && !an_start_d_reg;
	wire an_end = an_busy_reg && an_cnt_reg == an_last;
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			an_cnt_reg <= 22'h000000;
			an_busy_reg <= 1'b0;
			an_start_d_reg <= 1'b0;
			AN_DONE_OUT <= 1'b0;
		end else begin
			an_start_d_reg <= an_start;
			an_busy_reg <= an_fire || (an_busy_reg && !an_end);
			an_cnt_reg <= (an_fire || !an_busy_reg) ? 22'h000000 : an_cnt_reg + 22'h000001;
			AN_DONE_OUT <= an_end && !an_fire;
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	wire [qll_pkg::IRQ_W-1:0] irq_set = {AN_DONE_OUT, drop_now, latch_set};
	wire [qll_pkg::IRQ_W-1:0] irq_clr = (wr_stat && wstrb_reg[0]) ? wdata_reg[qll_pkg::IRQ_W-1:0] : '0;
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			irq_stat_reg <= '0;
			IRQ_OUT <= 1'b0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
			IRQ_OUT <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_mask_next);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_hit_skip;
		link_reg == qll_pkg::LINK_OK && loss_hit && skip_wait_stage && !no_signal_drop;
	endsequence
	sequence s_hit_wait;
		link_reg == qll_pkg::LINK_OK && loss_hit && !skip_wait_stage && !no_signal_drop;
	endsequence
	chk_skip_drop: assert property (@(posedge CLOCK_IN) disable iff (RST_IN) s_hit_skip |=> LINK_DOWN_OUT)
		else $error("skip set but link not dropped at once");
	chk_wait_stage: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		s_hit_wait ##1 !no_signal_drop [*2] |-> !LINK_DOWN_OUT)
		else $error("link dropped without the wait stage");
	chk_force_stop: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		no_signal_drop |=> TX_STOP_OUT && LINK_DOWN_OUT)
		else $error("no signal with forced drop but transmit not stopped");
	chk_latch_set: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		loss_hit |=> (latch_reg & $past(crit_hit)) == $past(crit_hit))
		else $error("met criterion not latched");
	chk_latch_clear: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		rd_ctrl && !loss_hit |=> latch_reg == '0)
		else $error("event bits not cleared by read");
	chk_latch_read: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		rd_ctrl |=> S_AXI_RDATA[qll_pkg::LATCH_LSB +: 5] == $past(latch_reg))
		else $error("read data lost latched events");
	chk_window_len: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		obs_end |-> obs_win_reg == ((loss_window_count == 5'h00) ? 5'h00 : loss_window_count - 5'h01))
		else $error("observation window length wrong");
	chk_xover_flip: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		xo_flip |=> MDIX_OUT != $past(MDIX_OUT))
		else $error("crossover did not flip");
	chk_an_length: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		AN_DONE_OUT |-> $past(an_cnt_reg) == $past(an_last))
		else $error("negotiation timer length wrong");
	chk_irq_level: assert property (@(posedge CLOCK_IN) disable iff (RST_IN)
		##1 IRQ_OUT == |(irq_stat_reg & irq_mask_reg))
		else $error("interrupt not tied to status and mask");
endmodule : qll_top

// >>> tb/qll_link_model.sv
`timescale 1ns/1ps
module qll_link_model (
	input wire logic clk_in,
	input wire logic [4:0] bad_in,
	input wire logic quiet_in,
	output logic energy_out = 1'b1,
	output logic [3:0] crit_out = 4'h0,
	output logic sig_out = 1'b1
);
	// A silent line carries neither energy nor signal
	always @(posedge clk_in) begin
		energy_out <= !quiet_in && !bad_in[0];
		crit_out <= bad_in[4:1];
		sig_out <= !quiet_in;
	end
endmodule : qll_link_model

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, an = 0, sl = 0, quiet = 0;
	logic [11:0] aw = 0, ar = 0;
	logic [31:0] wd = 0, seed = 32'hc6e0dcf4;
	logic [4:0] bad = 0;
	logic [3:0] ws = 4'hf;
	logic mref = 0;
	logic [33:0] exp_q[$];
	wire awr, wrdy, bv, arr, rv, ed, sd, ld, txs, ad, irq, mdx;
	wire [3:0] crit;
	wire [1:0] br, rr;
	wire [31:0] rdat;
	wire [6:0] sig = {mdx != mref, ad, ld, bv, rv, arr, awr && wrdy};
	int n_mismatch = 0, checked = 0, cnt;
	logic [11:0] ix[3] = '{12'h02c, 12'h02e, 12'h031};
	logic [15:0] mk[3] = '{16'h3fff, 16'h0777, 16'h71fd};
	logic [15:0] rs[3] = '{16'h141f, 16'h0221, 16'h10b0};
	int dur[4] = '{40, 400, 30, 70};
	always #2.5 clk = ~clk;
	qll_top #(.FAST_STEP_CYC(50), .ROBUST_STEP_CYC(60), .AN_T0_CYC(40), .AN_T2_CYC(30), .AN_T3_CYC(70)) u_dut (
		.CLOCK_IN(clk), .RST_IN(rst), .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
		.S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(br),
		.S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .ENERGY_DET_IN(ed),
		.MSE_BAD_IN(crit[0]), .MLT3_ERR_IN(crit[1]), .RX_ERR_IN(crit[2]), .DESCR_LOSS_IN(crit[3]),
		.SIGNAL_DET_IN(sd), .SLICER_STUCK_IN(sl), .AN_START_IN(an), .LINK_DOWN_OUT(ld), .TX_STOP_OUT(txs),
		.MDIX_OUT(mdx), .AN_DONE_OUT(ad), .IRQ_OUT(irq));
	qll_link_model u_link (.clk_in(clk), .bad_in(bad), .quiet_in(quiet), .energy_out(ed), .crit_out(crit),
		.sig_out(sd));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run
	task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// Handshakes are sampled at the falling edge, clear of the rising-edge updates
	task automatic wt(input int b);
		cnt = 0;
		do @(negedge clk); while (sig[b] !== 1'b1 && ++cnt < 3000);
		if (cnt >= 3000) begin
			n_mismatch++;
			complete_run();
		end
		@(posedge clk);
	endtask : wt
	task automatic wreg(input logic [11:0] a, input logic [15:0] d, input logic [1:0] e);
		@(posedge clk);
		exp_q.push_back({e, 32'h0});
		aw <= {a[9:0], 2'b00};
		wd <= {16'h0, d};
		awv <= 1;
		wv <= 1;
		bre <= 1;
		wt(0);
		awv <= 0;
		wv <= 0;
		wt(3);
		bre <= 0;
	endtask : wreg
	task automatic rreg(input logic [11:0] a, input logic [33:0] e);
		@(posedge clk);
		exp_q.push_back(e);
		ar <= {a[9:0], 2'b00};
		arv <= 1;
		rre <= 1;
		wt(1);
		arv <= 0;
		wt(2);
		rre <= 0;
	endtask : rreg
	always @(negedge clk)
		if ((rv && rre) || (bv && bre))
			check("resp", rv ? {rr, rdat} : {br, 32'h0}, exp_q.pop_front());
	initial begin
		logic [31:0] r;
		repeat (4) @(posedge clk);
		rst <= 0;
		for (int k = 0; k < 3; k++) begin
			r = rnd();
			rreg(ix[k], {18'h0, rs[k]});
			wreg(ix[k], r[15:0], 2'h0);
			rreg(ix[k], {18'h0, r[15:0] & mk[k]});
			wreg(ix[k], rs[k], 2'h0);
		end
		// Low byte strobe only: the upper byte keeps its reset value
		ws <= 4'h1;
		wreg(12'h02e, 16'hffff, 2'h0);
		ws <= 4'hf;
		rreg(12'h02e, {18'h0, 16'h0277});
		rreg(12'h02d, 34'h0);
		rreg(12'h07f, {2'h2, 32'h0});
		wreg(12'h07f, 16'hffff, 2'h2);
		for (int c = 0; c < 4; c++) begin
			wreg(12'h031, 16'h1090 | 16'(c << 5), 2'h0);
			an <= 1;
			wt(5);
			an <= 0;
			check("an_time", cnt >= dur[c] && cnt <= dur[c] + 6, 1);
		end
		sl <= 1;
		wreg(12'h041, 16'h0020, 2'h0);
		wreg(12'h02d, 16'h401f, 2'h0);
		bad <= 5'h04;
		wt(4);
		bad <= 0;
		// Let the window close so no late event lands after the clearing read
		repeat (4000) @(negedge clk);
		check("irq", irq, 1);
		rreg(12'h02d, {18'h0, 16'h641f});
		rreg(12'h02d, {18'h0, 16'h601f});
		rreg(12'h040, {2'h0, 32'h64});
		wreg(12'h041, 16'h0, 2'h0);
		@(negedge clk);
		check("irq_mask", irq, 0);
		wreg(12'h040, 16'h64, 2'h0);
		rreg(12'h040, 34'h0);
		// Short window, no skip: the drop waits out the maximum-wait stage
		wreg(12'h02c, 16'h021f, 2'h0);
		wreg(12'h02d, 16'h001f, 2'h0);
		bad <= 5'h04;
		wt(4);
		bad <= 0;
		check("wait_stage", cnt >= 2000 && cnt <= 2212, 1);
		wreg(12'h02d, 16'h8000, 2'h0);
		quiet <= 1;
		repeat (8) @(negedge clk);
		check("drop", {ld, txs}, 2'b11);
		// Crossover runs only while no signal is seen
		wreg(12'h042, 16'h0001, 2'h0);
		mref = mdx;
		wt(6);
		check("xo_fast", cnt >= 44 && cnt <= 56, 1);
		wreg(12'h042, 16'h0000, 2'h0);
		wreg(12'h042, 16'h0003, 2'h0);
		mref = mdx;
		wt(6);
		check("xo_robust", cnt >= 890 && cnt <= 906, 1);
		complete_run();
	end
endmodule : testbench
